// *** rtl/adc_result_output_port.sv ***
// Result output port of a 16-bit sampling converter.
//
// Function
// - Twos-complement gives 7fff/0000/8000; straight binary ffff/8000/0000.
// - Format select high picks straight binary, low twos-complement.
// - Byte bus driven only with read/convert high and chip select low.
// - Byte select low gives upper byte, high gives lower byte.
// - Byte select may change within a cycle; bus follows it.
// - Output register content is 0000 from reset until a conversion completes or an external serial frame shifts it.
// - Busy flag rises after the result is in the output register, or after the watchdog ends a conversion.
// - Busy falls within 85 ns of a start, stays low at most 2.5 us.
// - Parallel data valid at least 20 ns before busy rises.
// - Conversion starts when chip select and read/convert are low while the sequencer is idle.
// - Start requests are ignored while busy is low, except in its last low cycle, when the sequencer is already idle.
// - Serial data output is always driven.
// - Internal clock mode start launches the shift clock burst.
// - Internal burst shifts previous result MSB first, sixteen pulses.
// - Internal mode bits stay stable across both edges of their pulse.
// - After the burst the clock stays low; output shows chain level.
// - External mode shifts only with chip select low, read/convert high.
// - External MSB valid after first rise, LSB until seventeenth rise.
// - Chain bits sampled from the second pulse on, first appears after seventeenth rise.
// - Chain bits keep passing until the next result reloads the register.
// - Parallel reads keep the register; each external serial pulse after the first shifts it.
`timescale 1ns/1ps
`default_nettype none
module adc_result_output_port (
   input  wire logic       SYS_CLK,
   input  wire logic       RST_N,
   input  wire logic       CS_N,
   input  wire logic       READ_CONVERT,
   input  wire logic       BYTE_SELECT,
   input  wire logic       CODE_FORMAT_SELECT,
   input  wire logic       CLOCK_SOURCE_SELECT,
   input  wire logic       SERIAL_SHIFT_CLOCK_IN,
   input  wire logic       CHAIN_IN,
   input  wire logic [15:0] CONV_RESULT,
   input  wire logic       CONV_DONE,
   output logic            CONV_START,
   output logic            BUSY_N,
   output logic [7:0]      PARALLEL_BYTE_BUS_OUT,
   output logic            PARALLEL_BYTE_BUS_OE_N,
   output logic            SERIAL_DATA_OUT,
   output logic            SERIAL_SHIFT_CLOCK_OUT,
   output logic            SERIAL_SHIFT_CLOCK_OE_N
);
   // ****************************************************************
   // Declarations.
   // ****************************************************************
   localparam int BUSY_FALL_BOUND = adc_out_pkg::BUSY_FALL_MAX_CYC;

   logic [6:0]               pins_s;
   logic                     cs_s;
   logic                     rc_s;
   logic                     byte_s;
   logic                     fmt_s;
   logic                     src_s;
   logic                     sck_s;
   logic                     chain_s;
   logic                     sck_d_reg;
   adc_out_pkg::conv_state_t state_reg;
   logic [7:0]               cnt_reg;
   logic [15:0]              out_reg;
   logic [15:0]              burst_reg;
   logic                     chain_hold_reg;
   logic                     int_mode_reg;
   logic                     first_reg;
   logic                     start_fire;
   logic                     load;
   logic                     ext_sel;
   logic                     ext_rise;
   logic                     ext_shift;
   logic                     burst_fall;
   logic                     burst_active;
   logic [15:0]              format_mask;

   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   pin_sync #(
      .W    (adc_out_pkg::SYNC_W),
      .INIT (adc_out_pkg::SYNC_INIT)
   ) u_sync (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .d     ({CHAIN_IN, SERIAL_SHIFT_CLOCK_IN, CLOCK_SOURCE_SELECT,
               CODE_FORMAT_SELECT, BYTE_SELECT, READ_CONVERT, CS_N}),
      .q     (pins_s)
   );

   // Named views of the synchronised pins.
   assign cs_s    = pins_s[adc_out_pkg::IDX_CS];
   assign rc_s    = pins_s[adc_out_pkg::IDX_RC];
   assign byte_s  = pins_s[adc_out_pkg::IDX_BYTE];
   assign fmt_s   = pins_s[adc_out_pkg::IDX_FMT];
   assign src_s   = pins_s[adc_out_pkg::IDX_SRC];
   assign sck_s   = pins_s[adc_out_pkg::IDX_SCK];
   assign chain_s = pins_s[adc_out_pkg::IDX_CHAIN];

   // Delayed copy of the external clock for edge detection.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         sck_d_reg <= 1'b0;
      end else begin
         sck_d_reg <= sck_s;
      end
   end

   // ****************************************************************
   // Conversion control and busy flag.
   // ****************************************************************
   // Both lines low start a conversion, only from idle.
   assign start_fire = (state_reg == adc_out_pkg::IDLE) && !cs_s && !rc_s;
   assign load       = (state_reg == adc_out_pkg::CONVERTING) && CONV_DONE;

   // Sequencer: a watchdog ends a conversion that outlasts the busy limit.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state_reg <= adc_out_pkg::IDLE;
         cnt_reg   <= 8'h00;
      end else begin
         unique case (state_reg)
            adc_out_pkg::IDLE: begin
               cnt_reg <= 8'h00;
               if (start_fire) begin
                  state_reg <= adc_out_pkg::CONVERTING;
               end
            end
            adc_out_pkg::CONVERTING: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (load ||
                   cnt_reg == 8'(adc_out_pkg::CONV_LIMIT_CYC)) begin
                  state_reg <= adc_out_pkg::SETTLING;
                  cnt_reg   <= 8'h00;
               end
            end
            adc_out_pkg::SETTLING: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == 8'(adc_out_pkg::DATA_SETUP_CYC - 1)) begin
                  state_reg <= adc_out_pkg::IDLE;
               end
            end
         endcase
      end
   end

   // Busy is low in every state but idle; start strobe to the engine.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         BUSY_N     <= 1'b1;
         CONV_START <= 1'b0;
      end else begin
         BUSY_N     <= !(start_fire ||
                         (state_reg == adc_out_pkg::CONVERTING) ||
                         (state_reg == adc_out_pkg::SETTLING));
         CONV_START <= start_fire;
      end
   end

   // ****************************************************************
   // Output register.
   // ****************************************************************
   assign format_mask = fmt_s ? adc_out_pkg::FORMAT_FLIP : 16'h0000;
   assign ext_sel     = src_s && !cs_s && rc_s;
   assign ext_rise    = ext_sel && sck_s && !sck_d_reg;
   assign ext_shift   = ext_rise && !first_reg;

   // A reload beats a shift; chain bits follow until the reload.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         out_reg <= adc_out_pkg::OUT_RESET;
      end else if (load) begin
         out_reg <= CONV_RESULT ^ format_mask;
      end else if (ext_shift) begin
         out_reg <= {out_reg[14:0], chain_s};
      end
   end

   // First rising edge presents the MSB without shifting.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N || load || !ext_sel) begin
         first_reg <= 1'b1;
      end else if (ext_rise) begin
         first_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Parallel byte bus.
   // ****************************************************************
   // Enable and byte lane follow the pins; reading never shifts.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         PARALLEL_BYTE_BUS_OE_N <= 1'b1;
         PARALLEL_BYTE_BUS_OUT  <= 8'h00;
      end else begin
         PARALLEL_BYTE_BUS_OE_N <= !(!cs_s && rc_s);
         PARALLEL_BYTE_BUS_OUT  <= byte_s ? out_reg[7:0]
                                          : out_reg[15:8];
      end
   end

   // ****************************************************************
   // Internal shift clock burst and serial output.
   // ****************************************************************
   shift_burst u_burst (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .launch    (start_fire && !src_s),
      .clk_level (SERIAL_SHIFT_CLOCK_OUT),
      .fall_now  (burst_fall),
      .active    (burst_active)
   );

   // Snapshot of the previous result, shifted at each falling edge.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         burst_reg      <= adc_out_pkg::OUT_RESET;
         chain_hold_reg <= 1'b0;
         int_mode_reg   <= 1'b0;
      end else if (start_fire) begin
         burst_reg      <= out_reg;
         chain_hold_reg <= chain_s;
         int_mode_reg   <= !src_s;
      end else if (burst_fall) begin
         burst_reg <= {burst_reg[14:0], chain_hold_reg};
      end
   end

   // Serial line and clock pin direction; the data pin is never released.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         SERIAL_DATA_OUT         <= 1'b0;
         SERIAL_SHIFT_CLOCK_OE_N <= 1'b1;
      end else begin
         SERIAL_DATA_OUT         <= int_mode_reg ? burst_reg[15]
                                                 : out_reg[15];
         SERIAL_SHIFT_CLOCK_OE_N <= src_s;
      end
   end

   // ****************************************************************
   // Assertions and their helper logic.
   // ****************************************************************
   logic [7:0]  busy_low_cnt;
   logic [4:0]  pulse_cnt;
   logic        was_idle;
   logic [15:0] load_val;
   logic [7:0]  out_hi;
   logic [7:0]  out_lo;

   assign out_hi   = out_reg[15:8];
   assign out_lo   = out_reg[7:0];
   assign load_val = CONV_RESULT ^ format_mask;

   // Counts busy low cycles, burst pulses and remembers idle.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         busy_low_cnt <= 8'h00;
         pulse_cnt    <= 5'h00;
         was_idle     <= 1'b1;
      end else begin
         busy_low_cnt <= BUSY_N ? 8'h00 : busy_low_cnt + 8'h01;
         if (start_fire && !src_s) begin
            pulse_cnt <= 5'h00;
         end else if (burst_fall) begin
            pulse_cnt <= pulse_cnt + 5'h01;
         end
         was_idle <= (state_reg == adc_out_pkg::IDLE);
      end
   end

   sequence s_load;
      load;
   endsequence

   sequence s_release;
      !BUSY_N ##1 BUSY_N;
   endsequence

   property p_code_format;
      @(posedge SYS_CLK) disable iff (!RST_N)
      load |=> out_reg == $past(load_val);
   endproperty
   a_code_format: assert property (p_code_format)
      else $error("Loaded result does not match the selected code format.");

   property p_bus_enable;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (!cs_s && rc_s) |=> !PARALLEL_BYTE_BUS_OE_N;
   endproperty
   a_bus_enable: assert property (p_bus_enable)
      else $error("Byte bus not driven while read is selected.");

   property p_byte_lane;
      @(posedge SYS_CLK) disable iff (!RST_N)
      byte_s |=> PARALLEL_BYTE_BUS_OUT == $past(out_lo);
   endproperty
   a_byte_lane: assert property (p_byte_lane)
      else $error("Lower byte not on the bus with byte select high.");

   property p_busy_fall;
      @(posedge SYS_CLK) disable iff (!RST_N)
      start_fire |-> ##[1:BUSY_FALL_BOUND] !BUSY_N;
   endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("Busy did not fall in time after a start.");

   property p_busy_low_max;
      @(posedge SYS_CLK) disable iff (!RST_N)
      busy_low_cnt <= 8'(adc_out_pkg::BUSY_LOW_MAX_CYC);
   endproperty
   a_busy_low_max: assert property (p_busy_low_max)
      else $error("Busy stayed low too long.");

   property p_result_before_busy;
      @(posedge SYS_CLK) disable iff (!RST_N)
      s_load |-> ##2 s_release;
   endproperty
   a_result_before_busy: assert property (p_result_before_busy)
      else $error("Busy did not rise two cycles after the load.");

   property p_ignore_busy;
      @(posedge SYS_CLK) disable iff (!RST_N)
      CONV_START |-> was_idle && !BUSY_N;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("Conversion started while busy.");

   property p_burst_launch;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (start_fire && !src_s) |=> burst_active ##1 burst_active;
   endproperty
   a_burst_launch: assert property (p_burst_launch)
      else $error("Internal burst not launched by a start.");

   property p_burst_count;
      @(posedge SYS_CLK) disable iff (!RST_N)
      !burst_active |-> !SERIAL_SHIFT_CLOCK_OUT &&
                        pulse_cnt <= 5'(adc_out_pkg::BURST_PULSES);
   endproperty
   a_burst_count: assert property (p_burst_count)
      else $error("Burst pulse count or idle clock level wrong.");

   property p_parallel_no_shift;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (!load && !ext_shift) |=> $stable(out_reg);
   endproperty
   a_parallel_no_shift: assert property (p_parallel_no_shift)
      else $error("Output register changed without a load or shift.");
endmodule : adc_result_output_port
`default_nettype wire

// *** rtl/adc_out_pkg.sv ***
// Constants and types shared by the converter result output port.
package adc_out_pkg;
   // ****************************************************************
   // Clock and timing.
   // ****************************************************************
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int SYS_CLK_KHZ       = 50000;
   localparam int INT_CLK_KHZ       = 900;
   localparam int INT_HALF_CYC      = (SYS_CLK_KHZ / INT_CLK_KHZ) / 2;
   localparam int BUSY_FALL_MAX_NS  = 85;
   localparam int BUSY_FALL_MAX_CYC = BUSY_FALL_MAX_NS / SYS_CLK_PERIOD_NS;
   localparam int BUSY_LOW_MAX_NS   = 2500;
   localparam int BUSY_LOW_MAX_CYC  = BUSY_LOW_MAX_NS / SYS_CLK_PERIOD_NS;
   localparam int DATA_SETUP_NS     = 20;
   localparam int DATA_SETUP_CYC    =
      (DATA_SETUP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int CONV_LIMIT_CYC    = BUSY_LOW_MAX_CYC - DATA_SETUP_CYC - 2;
   localparam int BURST_PULSES      = 16;
   // ****************************************************************
   // Result codes and reset values.
   // ****************************************************************
   localparam logic [15:0] TWOS_POS_FS = 16'h7fff;
   localparam logic [15:0] TWOS_MID    = 16'h0000;
   localparam logic [15:0] TWOS_NEG_FS = 16'h8000;
   localparam logic [15:0] BIN_POS_FS  = 16'hffff;
   localparam logic [15:0] BIN_MID     = 16'h8000;
   localparam logic [15:0] BIN_NEG_FS  = 16'h0000;
   localparam logic [15:0] FORMAT_FLIP = 16'h8000;
   localparam logic [15:0] OUT_RESET   = 16'h0000;
   // ****************************************************************
   // Synchroniser bit positions and their idle levels.
   // ****************************************************************
   localparam int IDX_CS    = 0;
   localparam int IDX_RC    = 1;
   localparam int IDX_BYTE  = 2;
   localparam int IDX_FMT   = 3;
   localparam int IDX_SRC   = 4;
   localparam int IDX_SCK   = 5;
   localparam int IDX_CHAIN = 6;
   localparam int SYNC_W    = 7;
   localparam logic [6:0] SYNC_INIT = 7'h03;
   typedef enum {IDLE, CONVERTING, SETTLING} conv_state_t;
endpackage : adc_out_pkg

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for the asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int         W    = 1,
   parameter logic [6:0] INIT = 7'h00
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // Each bit passes two flops; only the second flop reads the first.
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta_reg[i] <= INIT[i];
               q[i]        <= INIT[i];
            end else begin
               meta_reg[i] <= d[i];
               q[i]        <= meta_reg[i];
            end
         end
      end
   endgenerate
endmodule : pin_sync
`default_nettype wire

// *** rtl/shift_burst.sv ***
// Internal shift clock burst generator of sixteen pulses.
`timescale 1ns/1ps
`default_nettype none
module shift_burst (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic launch,
   output logic      clk_level,
   output logic      fall_now,
   output logic      active
);
   logic [4:0] div_reg;
   logic [4:0] pulse_reg;
   logic       tick;

   // Divider enable pulse sets the half period of the shift clock.
   assign tick     = active && (div_reg == 5'(adc_out_pkg::INT_HALF_CYC - 1));
   assign fall_now = tick && clk_level;

   // Half period counter.
   always_ff @(posedge clk) begin
      if (!rst_n || launch || tick) begin
         div_reg <= 5'h00;
      end else if (active) begin
         div_reg <= div_reg + 5'h01;
      end
   end

   // Clock level, pulse count and end of burst.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clk_level <= 1'b0;
         pulse_reg <= 5'h00;
         active    <= 1'b0;
      end else if (launch) begin
         clk_level <= 1'b0;
         pulse_reg <= 5'h00;
         active    <= 1'b1;
      end else if (tick) begin
         clk_level <= ~clk_level;
         if (clk_level) begin
            pulse_reg <= pulse_reg + 5'h01;
            if (pulse_reg == 5'(adc_out_pkg::BURST_PULSES - 1)) begin
               active <= 1'b0;
            end
         end
      end
   end
endmodule : shift_burst
`default_nettype wire

// *** verif/host_serial_model.sv ***
// Host model that clocks the serial result line and captures bursts.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   input  wire logic serial_data_out,
   input  wire logic burst_clk,
   output logic      ext_clk,
   output logic      chain
);
   logic [15:0] burst_word = 16'h0000;
   logic [15:0] fall_word = 16'h0000;
   int          burst_count = 0;
   // The shift clock stands low outside frames.
   initial begin
      ext_clk = 1'b0;
      chain = 1'b0;
   end
   // Takes one bit at each rise of the internal burst clock.
   always @(posedge burst_clk) begin
      burst_word = {burst_word[14:0], serial_data_out};
      burst_count = burst_count + 1;
   end
   // Takes one bit at each fall of the internal burst clock.
   always @(negedge burst_clk) begin
      fall_word = {fall_word[14:0], serial_data_out};
   end
   // Clears the capture count and sets the chain level ahead of a burst.
   task automatic arm(input logic level);
      burst_count = 0;
      chain <= level;
   endtask : arm
   // One 160 ns pulse, high half the period; sees data before the rise.
   task automatic pulse(input logic cin, output logic seen);
      #5;
      chain = cin;
      #40;
      seen = serial_data_out;
      ext_clk = 1'b1;
      #80;
      ext_clk = 1'b0;
      #35;
   endtask : pulse
endmodule : host_serial_model
`default_nettype wire

// *** verif/adc_result_output_port_test.sv ***
// Self-checking bench for the converter result output port.
`timescale 1ns/1ps
`default_nettype none
module adc_result_output_port_test;
   // ****************************************************************
   // Pins, engine stand-in and observation queue.
   // ****************************************************************
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs_n = 1'b1;
   logic        read_convert = 1'b1;
   logic        byte_select = 1'b0;
   logic        code_format_select = 1'b0;
   logic        clock_source_select = 1'b1;
   logic        conv_done = 1'b0;
   logic [15:0] conv_result = 16'h0000;
   logic [15:0] next_result = 16'h0000;
   logic        conv_start, busy_n, bus_oe_n, serial_data_out, sclk_out, sclk_oe_n;
   logic [7:0]  bus;
   logic        ext_clk, chain;
   wire logic   sclk_pin = sclk_oe_n ? ext_clk : sclk_out;
   logic [15:0] seen;
   logic [15:0] exp_q[$];
   int          starts = 0;
   int          bad_count = 0;
   int          n_compared = 0;
   event        got;
   // Free-running 50 MHz system clock.
   always #10 sys_clk = ~sys_clk;
   adc_result_output_port i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
      .CS_N(cs_n), .READ_CONVERT(read_convert), .BYTE_SELECT(byte_select),
      .CODE_FORMAT_SELECT(code_format_select),
      .CLOCK_SOURCE_SELECT(clock_source_select),
      .SERIAL_SHIFT_CLOCK_IN(sclk_pin), .CHAIN_IN(chain),
      .CONV_RESULT(conv_result), .CONV_DONE(conv_done),
      .CONV_START(conv_start), .BUSY_N(busy_n),
      .PARALLEL_BYTE_BUS_OUT(bus), .PARALLEL_BYTE_BUS_OE_N(bus_oe_n),
      .SERIAL_DATA_OUT(serial_data_out), .SERIAL_SHIFT_CLOCK_OUT(sclk_out),
      .SERIAL_SHIFT_CLOCK_OE_N(sclk_oe_n));
   host_serial_model i_host (.serial_data_out(serial_data_out), .burst_clk(sclk_pin),
      .ext_clk(ext_clk), .chain(chain));
   // Counts every start pulse sent to the engine.
   always @(posedge sys_clk) begin
      if (conv_start === 1'b1) starts++;
   end
   // Engine stand-in answers each start 100 cycles later.
   always @(posedge sys_clk) begin
      if (conv_start === 1'b1) begin
         repeat (100) @(posedge sys_clk);
         conv_result <= next_result;
         conv_done <= 1'b1;
         @(posedge sys_clk);
         conv_done <= 1'b0;
      end
   end
   // Takes the oldest expectation whenever an observation appears.
   always @(got) begin
      n_compared++;
      if (exp_q.size() == 0 || exp_q[0] !== seen) begin
         bad_count++;
         $display("mismatch at %0t: saw %h", $time, seen);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
   end
   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task automatic check(input logic [15:0] e, input logic [15:0] o);
      exp_q.push_back(e);
      seen = o;
      ->got;
      #1;
   endtask : check
   // Bus image: 0100 when released, else the driven byte.
   function automatic logic [15:0] obs_bus();
      return bus_oe_n ? 16'h0100 : {8'h00, bus};
   endfunction : obs_bus
   task automatic read_byte(input logic sel, input logic [7:0] v);
      @(posedge sys_clk);
      byte_select <= sel;
      repeat (4) @(posedge sys_clk);
      #1 check({8'h00, v}, obs_bus());
   endtask : read_byte
   // Starts one conversion, tries a refused restart, waits for the end.
   task automatic convert(input logic [15:0] r, input logic [7:0] prev_hi,
                          input logic [7:0] new_hi, input logic chk);
      int s0;
      int k;
      logic [15:0] pre;
      s0 = starts;
      next_result = r;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      read_convert <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 check(16'h0100, {6'h00, busy_n, bus_oe_n, 8'h00});
      @(posedge sys_clk);
      cs_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      read_convert <= 1'b1;
      if (chk) read_byte(1'b0, prev_hi);
      for (k = 0; k < 200 && busy_n !== 1'b1; k++) begin
         pre = obs_bus();
         @(posedge sys_clk);
         #1;
      end
      check({8'h00, new_hi}, pre);
      check({8'h00, new_hi}, obs_bus());
      check(16'h8001, {busy_n, 11'h000, 4'(starts - s0)});
   endtask : convert
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // Cuts a hang short.
   initial begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end
   // Main sequence: parallel codes, internal burst, external frame.
   initial begin
      logic [15:0] codes[3] = '{16'h7fff, 16'h0000, 16'h8000};
      logic [15:0] r;
      logic [15:0] nxt;
      logic [15:0] last;
      logic [15:0] word;
      logic        b;
      logic        c0;
      int          k;
      r = 16'($urandom(14));
      last = 16'h0000;
      word = 16'h0000;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = (i < 6) ? codes[i / 2] : 16'($urandom);
         nxt = i[0] ? (r ^ 16'h8000) : r;
         @(posedge sys_clk);
         code_format_select <= i[0];
         if (i[1]) begin
            cs_n <= 1'b1;
            read_convert <= 1'b0;
            repeat (4) @(posedge sys_clk);
            #1 check(16'h0100, obs_bus());
         end
         convert(r, last[15:8], nxt[15:8], i > 0);
         last = nxt;
         read_byte(1'b0, last[15:8]);
         read_byte(1'b1, last[7:0]);
         read_byte(1'b0, last[15:8]);
      end
      @(posedge sys_clk);
      clock_source_select <= 1'b0;
      code_format_select <= 1'b0;
      c0 = 1'($urandom);
      i_host.arm(c0);
      r = 16'($urandom);
      convert(r, last[15:8], r[15:8], 1'b1);
      for (k = 0; k < 2000 && i_host.burst_count < 16; k++)
         @(posedge sys_clk);
      repeat (100) @(posedge sys_clk);
      #1 check(last, i_host.burst_word);
      check(last, i_host.fall_word);
      check({8'h10, 7'h00, c0},
            {8'(i_host.burst_count), 6'h00, sclk_out, serial_data_out});
      @(posedge sys_clk);
      clock_source_select <= 1'b1;
      r = 16'($urandom);
      convert(r, 8'h00, r[15:8], 1'b0);
      @(posedge sys_clk);
      cs_n <= 1'b1;
      i_host.pulse(1'b0, b);
      i_host.pulse(1'b1, b);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (k = 1; k <= 18; k++) begin
         i_host.pulse(k < 3 ? c0 : ~c0, b);
         if (k >= 2 && k <= 17) word = {word[14:0], b};
      end
      check(r, word);
      check({15'h0000, c0}, {15'h0000, b});
      close_out();
   end
endmodule : adc_result_output_port_test
`default_nettype wire
